/* logic/tgat_pkg.sv */
// Contract
// - Each group's sampling clock is the module clock divided by 2*(divider field + 1).
// - The charge phase lasts as many sampling clock cycles as the charge-length field.
// - After each charge transfer a settle phase lasts as many cycles as the settle field.
// - The discharge length is shifted left by the two-bit discharge-scale field.
// - With sync-start set, acquisition waits for a falling edge on the sync line.
// - With spread spectrum set, the drive timing of that group's sensors is dithered.
// - Before charging, the capacitors are discharged for the scaled discharge length.
// - A measurement ends once the burst count reaches the 16-bit maximum-count field.
// - Each of the two groups has its own pair of read/write timing registers, reset to zero.
// - Pairs with mode code 001 use group A timing, pairs with code 010 use group B timing.
`default_nettype none

package tgat_pkg;

    // Register map, byte addresses on the local port
    localparam int TGAT_GROUPS = 2;
    localparam int TGAT_ADDR_W = 8;
    localparam logic [7:0] TGAT_OFS_GROUP_A_CFG0 = 8'h20;
    localparam logic [7:0] TGAT_OFS_GROUP_A_CFG1 = 8'h24;
    localparam logic [7:0] TGAT_OFS_GROUP_B_CFG0 = 8'h28;
    localparam logic [7:0] TGAT_OFS_GROUP_B_CFG1 = 8'h2C;
    localparam logic [7:0] TGAT_GROUP_STRIDE = 8'h08;
    localparam logic [31:0] TGAT_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] TGAT_CFG0_MASK = 32'hFFFF_FFFF;
    localparam logic [31:0] TGAT_CFG1_MASK = 32'h33FF_FFFF;

    // Field positions
    localparam int TGAT_DIV_LSB = 16;
    localparam int TGAT_CHARGE_PHASE_LENGTH_LSB = 8;
    localparam int TGAT_SETTLE_PHASE_LENGTH_LSB = 0;
    localparam int TGAT_SCALE_LSB = 28;
    localparam int TGAT_SYNC_BIT = 25;
    localparam int TGAT_SPREAD_BIT = 24;
    localparam int TGAT_DISCHARGE_PHASE_LENGTH_LSB = 16;
    localparam int TGAT_MAX_LSB = 0;

    // Sense pair mode codes
    localparam logic [2:0] TGAT_MODE_GROUP_A = 3'h1;
    localparam logic [2:0] TGAT_MODE_GROUP_B = 3'h2;

    // Phase counter width: 8-bit length shifted by up to 3
    localparam int TGAT_PHASE_W = 11;
    localparam int TGAT_LFSR_W = 8;
    localparam logic [TGAT_LFSR_W-1:0] TGAT_LFSR_SEED = 8'h01;

    typedef struct packed {
        logic [TGAT_ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic write;
        logic read;
    } tgat_bus_req_t;

    typedef struct packed {
        logic [15:0] div;
        logic [7:0] charge_phase_length;
        logic [7:0] settle_phase_length;
        logic [1:0] scale;
        logic sync;
        logic spread;
        logic [7:0] discharge_phase_length;
        logic [15:0] max;
    } tgat_timing_t;

    // Splits the two timing words of a group into fields
    function automatic tgat_timing_t tgat_unpack(input logic [31:0] c0, input logic [31:0] c1);
        tgat_timing_t t;
        t.div = c0[TGAT_DIV_LSB +: 16];
        t.charge_phase_length = c0[TGAT_CHARGE_PHASE_LENGTH_LSB +: 8];
        t.settle_phase_length = c0[TGAT_SETTLE_PHASE_LENGTH_LSB +: 8];
        t.scale = c1[TGAT_SCALE_LSB +: 2];
        t.sync = c1[TGAT_SYNC_BIT];
        t.spread = c1[TGAT_SPREAD_BIT];
        t.discharge_phase_length = c1[TGAT_DISCHARGE_PHASE_LENGTH_LSB +: 8];
        t.max = c1[TGAT_MAX_LSB +: 16];
        return t;
    endfunction

    // Scaled discharge duration in sampling cycles
    function automatic logic [TGAT_PHASE_W-1:0] tgat_disch_len(input tgat_timing_t t);
        return {3'h0, t.discharge_phase_length} << t.scale;
    endfunction

    // Byte address of a group's first or second timing word
    function automatic logic [7:0] tgat_cfg_addr(input int g, input logic second);
        return TGAT_OFS_GROUP_A_CFG0 + 8'(g) * TGAT_GROUP_STRIDE
            + (second ? (TGAT_OFS_GROUP_A_CFG1 - TGAT_OFS_GROUP_A_CFG0) : 8'h00);
    endfunction

endpackage

`default_nettype wire

/* logic/tgat_prescaler.sv */
`default_nettype none

module tgat_prescaler
    import tgat_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_run,
    input wire logic [DIV_W-1:0] i_div,
    output logic o_clock,
    output logic o_tick
);

    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W+1:0] gap_r;
    logic seen_r;

    // Half period of div+1 module clocks, tick on each rising edge
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            cnt_r <= '0;
            o_clock <= 1'b0;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt_r <= '0;
            o_clock <= 1'b0;
            o_tick <= 1'b0;
        end else if (cnt_r == i_div) begin
            cnt_r <= '0;
            o_clock <= ~o_clock;
            o_tick <= ~o_clock;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            o_tick <= 1'b0;
        end
    end

    // Cycles since the last tick, for checking only
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            gap_r <= '0;
            seen_r <= 1'b0;
        end else if (!i_run) begin
            gap_r <= '0;
            seen_r <= 1'b0;
        end else begin
            gap_r <= o_tick ? (DIV_W + 2)'(1) : gap_r + 1'b1;
            seen_r <= seen_r | o_tick;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    tick_period_a: assert property (
        o_tick && seen_r && $stable(i_div) |-> gap_r == {{1'b0, i_div} + 1'b1, 1'b0})
        else $error("sampling tick period differs from twice div plus one");

endmodule

`default_nettype wire

/* logic/tgat_lfsr.sv */
`default_nettype none

module tgat_lfsr
    import tgat_pkg::*;
#(
    parameter int W = TGAT_LFSR_W
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_step,
    output logic [W-1:0] o_value
);

    // Galois-free Fibonacci form, taps 8,6,5,4
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_value <= TGAT_LFSR_SEED;
        end else if (i_step) begin
            o_value <= {o_value[W-2:0], o_value[W-1] ^ o_value[5] ^ o_value[4] ^ o_value[3]};
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    dither_moves_a: assert property (i_step |=> o_value != $past(o_value))
        else $error("spread sequence did not advance");

endmodule

`default_nettype wire

/* logic/tgat_top.sv */
// The implementer's own choice: the strobed register port.
`default_nettype none

module tgat_top
    import tgat_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire tgat_bus_req_t i_bus,
    output logic [31:0] o_rdata,
    input wire logic i_acq_start,
    input wire logic [2:0] i_pair_mode,
    input wire logic i_sync,
    input wire logic i_threshold_met,
    output logic o_discharge,
    output logic o_charge,
    output logic o_settle,
    output logic o_sample_clock,
    output logic o_busy,
    output logic o_group_b,
    output logic o_done,
    output logic o_max_reached,
    output logic [15:0] o_count
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SYNC,
        ST_DISCH,
        ST_CHARGE,
        ST_SETTLE
    } tgat_state_t;

    logic [31:0] cfg0_r [TGAT_GROUPS];
    logic [31:0] cfg1_r [TGAT_GROUPS];
    tgat_timing_t grp_t [TGAT_GROUPS];
    logic [31:0] rd_word;

    tgat_state_t state_r;
    tgat_timing_t cur_r;
    logic group_b_r;
    logic sync_prev_r;
    logic [TGAT_PHASE_W-1:0] phase_cnt_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic finish_nxt;
    logic start_ok;
    logic start_b;
    tgat_timing_t sel_t;
    logic [TGAT_PHASE_W-1:0] charge_len;
    logic load_charge;
    logic tick;
    logic presc_clock;
    logic [TGAT_LFSR_W-1:0] lfsr_value;
    logic sync_fall;

    // Per-group timing registers
    generate
        for (genvar g = 0; g < TGAT_GROUPS; g++) begin : g_cfg
            always_ff @(posedge i_clock or posedge i_reset) begin
                if (i_reset) begin
                    cfg0_r[g] <= TGAT_CFG_RESET;
                    cfg1_r[g] <= TGAT_CFG_RESET;
                end else if (i_bus.write) begin
                    if (i_bus.addr == tgat_cfg_addr(g, 1'b0)) begin
                        cfg0_r[g] <= i_bus.wdata & TGAT_CFG0_MASK;
                    end
                    if (i_bus.addr == tgat_cfg_addr(g, 1'b1)) begin
                        cfg1_r[g] <= i_bus.wdata & TGAT_CFG1_MASK;
                    end
                end
            end
            assign grp_t[g] = tgat_unpack(cfg0_r[g], cfg1_r[g]);
        end
    endgenerate

    // Read decode; unmapped addresses read zero
    always_comb begin
        rd_word = '0;
        for (int g = 0; g < TGAT_GROUPS; g++) begin
            if (i_bus.addr == tgat_cfg_addr(g, 1'b0)) begin
                rd_word = cfg0_r[g];
            end
            if (i_bus.addr == tgat_cfg_addr(g, 1'b1)) begin
                rd_word = cfg1_r[g];
            end
        end
    end

    // Read data in the cycle after the strobe
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_bus.read ? rd_word : 32'h0000_0000;
        end
    end

    // Group selection from the pair's mode code
    assign start_b = (i_pair_mode == TGAT_MODE_GROUP_B);
    assign start_ok = i_acq_start && (state_r == ST_IDLE)
        && (i_pair_mode == TGAT_MODE_GROUP_A || start_b);
    assign sel_t = start_b ? grp_t[1] : grp_t[0];

    // Charge length with optional dither of zero to three cycles
    assign charge_len = {3'h0, cur_r.charge_phase_length}
        + (cur_r.spread ? {9'h000, lfsr_value[1:0]} : 11'h000);
    assign load_charge = ((state_r == ST_DISCH) || (state_r == ST_SETTLE && !finish_nxt))
        && phase_cnt_r == '0;

    assign sync_fall = sync_prev_r && !i_sync;
    assign count_nxt = count_r + 16'h0001;
    assign finish_nxt = i_threshold_met || (count_nxt >= cur_r.max);

    tgat_prescaler #(
        .DIV_W(16)
    ) u_prescaler (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_run(state_r != ST_IDLE && state_r != ST_SYNC),
        .i_div(cur_r.div),
        .o_clock(presc_clock),
        .o_tick(tick)
    );

    tgat_lfsr #(
        .W(TGAT_LFSR_W)
    ) u_lfsr (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_step(load_charge && cur_r.spread),
        .o_value(lfsr_value)
    );

    // Previous sync level for falling edge detection
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            sync_prev_r <= 1'b0;
        end else begin
            sync_prev_r <= i_sync;
        end
    end

    // Latched timing of the group being measured
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            cur_r <= '0;
            group_b_r <= 1'b0;
        end else if (start_ok) begin
            cur_r <= sel_t;
            group_b_r <= start_b;
        end
    end

    // Acquisition sequencer
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state_r <= ST_IDLE;
            phase_cnt_r <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start_ok) begin
                        phase_cnt_r <= tgat_disch_len(sel_t);
                        state_r <= sel_t.sync ? ST_SYNC : ST_DISCH;
                    end
                end
                ST_SYNC: begin
                    if (sync_fall) begin
                        state_r <= ST_DISCH;
                    end
                end
                ST_DISCH: begin
                    if (phase_cnt_r == '0) begin
                        phase_cnt_r <= charge_len;
                        state_r <= ST_CHARGE;
                    end else if (tick) begin
                        phase_cnt_r <= phase_cnt_r - 1'b1;
                    end
                end
                ST_CHARGE: begin
                    if (phase_cnt_r == '0) begin
                        phase_cnt_r <= {3'h0, cur_r.settle_phase_length};
                        state_r <= ST_SETTLE;
                    end else if (tick) begin
                        phase_cnt_r <= phase_cnt_r - 1'b1;
                    end
                end
                ST_SETTLE: begin
                    if (phase_cnt_r == '0) begin
                        if (finish_nxt) begin
                            state_r <= ST_IDLE;
                        end else begin
                            phase_cnt_r <= charge_len;
                            state_r <= ST_CHARGE;
                        end
                    end else if (tick) begin
                        phase_cnt_r <= phase_cnt_r - 1'b1;
                    end
                end
            endcase
        end
    end

    // Burst counter and result
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            count_r <= '0;
            o_count <= '0;
            o_done <= 1'b0;
            o_max_reached <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (start_ok) begin
                count_r <= '0;
            end else if (state_r == ST_SETTLE && phase_cnt_r == '0) begin
                count_r <= count_nxt;
                if (finish_nxt) begin
                    o_count <= count_nxt;
                    o_done <= 1'b1;
                    o_max_reached <= !i_threshold_met;
                end
            end
        end
    end

    // Pin and status outputs, one cycle behind the state
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_discharge <= 1'b0;
            o_charge <= 1'b0;
            o_settle <= 1'b0;
            o_sample_clock <= 1'b0;
            o_busy <= 1'b0;
            o_group_b <= 1'b0;
        end else begin
            o_discharge <= (state_r == ST_DISCH);
            o_charge <= (state_r == ST_CHARGE);
            o_settle <= (state_r == ST_SETTLE);
            o_sample_clock <= presc_clock;
            o_busy <= (state_r != ST_IDLE);
            o_group_b <= group_b_r;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    start_leaves_idle_a: assert property (start_ok |=> state_r != ST_IDLE)
        else $error("accepted start did not leave idle");

    group_pick_a: assert property (
        start_ok |=> group_b_r == $past(start_b) ##1 o_group_b == group_b_r)
        else $error("wrong timing group selected for pair mode");

    sync_hold_a: assert property (
        state_r == ST_SYNC && !sync_fall |=> state_r == ST_SYNC)
        else $error("acquisition began without sync falling edge");

    disch_load_a: assert property (
        start_ok |=> phase_cnt_r == tgat_disch_len(cur_r))
        else $error("discharge length not scaled by shift field");

    disch_before_charge_a: assert property (
        state_r == ST_CHARGE && $past(state_r) != ST_CHARGE |-> $past(state_r) == ST_DISCH
        || $past(state_r) == ST_SETTLE)
        else $error("charge entered without discharge or settle");

    charge_hold_a: assert property (
        state_r == ST_CHARGE && phase_cnt_r != '0 && !tick |=> state_r == ST_CHARGE
        && $stable(phase_cnt_r))
        else $error("charge phase ended early");

    settle_load_a: assert property (
        state_r == ST_CHARGE && phase_cnt_r == '0 |=> state_r == ST_SETTLE
        && phase_cnt_r == {3'h0, cur_r.settle_phase_length})
        else $error("settle phase length wrong");

    max_stop_a: assert property (
        state_r == ST_SETTLE && phase_cnt_r == '0 && count_nxt >= cur_r.max |=> o_done
        && state_r == ST_IDLE && o_count == $past(count_nxt))
        else $error("measurement ran past the maximum count");

    cfg_write_a: assert property (
        i_bus.write && i_bus.addr == TGAT_OFS_GROUP_B_CFG1 |=> cfg1_r[1]
        == ($past(i_bus.wdata) & TGAT_CFG1_MASK))
        else $error("group B second timing word not written");

    done_on_max_c: cover property (o_done && o_max_reached);
    done_on_thr_c: cover property (o_done && !o_max_reached);
    sync_start_c: cover property (state_r == ST_SYNC ##1 state_r == ST_DISCH);
    group_b_c: cover property (start_ok && start_b);

endmodule

`default_nettype wire

/* sim/tgat_electrode_model.sv */
`default_nettype none

module tgat_electrode_model (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_discharge,
    input wire logic i_charge,
    input wire logic i_settle,
    input wire logic [15:0] i_need,
    output logic o_threshold_met
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] burst_r;
    logic charge_d_r;
    logic flip_r;

    // Counts charge transfers since the last discharge
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            burst_r <= 16'h0000;
            charge_d_r <= 1'b0;
            flip_r <= 1'b0;
        end else begin
            charge_d_r <= i_charge;
            flip_r <= ~flip_r;
            if (i_discharge) begin
                burst_r <= 16'h0000;
            end else if (i_charge && !charge_d_r) begin
                burst_r <= burst_r + 16'h0001;
            end
        end
    end

    // Comparator meaningful only while settling, toggles otherwise
    assign o_threshold_met = i_settle ? (burst_r >= i_need) : flip_r;
endmodule

`default_nettype wire

/* sim/touch_group_acq_timing_tb.sv */
`default_nettype none

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("Error at %0t: got %h want %h", $time, (a), (b)); end end

module touch_group_acq_timing_tb;
    import tgat_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic i_clock;
    logic i_reset = 1'b1;
    tgat_bus_req_t bus;
    logic acq_start, sync_line, thr;
    logic [2:0] pair_mode;
    logic [15:0] need_r;
    logic [31:0] o_rdata, d;
    logic o_discharge, o_charge, o_settle, o_sample_clock, o_busy;
    logic o_group_b, o_done, o_max_reached;
    logic [15:0] o_count;
    logic [31:0] regs [4];
    logic [7:0] a;
    int num_errors = 0;
    int n_tests = 0;
    int i, s, m;

    tgat_top u_dut (
        .i_clock(i_clock), .i_reset(i_reset), .i_bus(bus), .o_rdata(o_rdata),
        .i_acq_start(acq_start), .i_pair_mode(pair_mode), .i_sync(sync_line),
        .i_threshold_met(thr), .o_discharge(o_discharge), .o_charge(o_charge),
        .o_settle(o_settle), .o_sample_clock(o_sample_clock), .o_busy(o_busy),
        .o_group_b(o_group_b), .o_done(o_done), .o_max_reached(o_max_reached),
        .o_count(o_count)
    );

    tgat_electrode_model u_pads (
        .i_clock(i_clock), .i_reset(i_reset), .i_discharge(o_discharge),
        .i_charge(o_charge), .i_settle(o_settle), .i_need(need_r), .o_threshold_met(thr)
    );

    // Clock generator
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Register file model, unmapped reads zero
    function automatic logic [31:0] exp_rd(input logic [7:0] ad);
        return (ad >= 8'h20 && ad <= 8'h2C && ad[1:0] == 2'b00) ? regs[ad[3:2]] : 32'h0;
    endfunction

    // Phase length window in module clocks, tick alignment tolerated
    function automatic bit inr(input int n, input int len, input int p, input int x);
        return n >= len * p - p + 1 && n <= len * p + 1 + x * p;
    endfunction

    task automatic wr(input logic [7:0] ad, input logic [31:0] dw);
        @(posedge i_clock);
        bus.addr <= ad;
        bus.wdata <= dw;
        bus.write <= 1'b1;
        @(posedge i_clock);
        bus.write <= 1'b0;
        if (ad >= 8'h20 && ad <= 8'h2C && ad[1:0] == 2'b00) begin
            regs[ad[3:2]] = ad[2] ? (dw & TGAT_CFG1_MASK) : dw;
        end
    endtask

    task automatic rd(input logic [7:0] ad, output logic [31:0] dr);
        @(posedge i_clock);
        bus.addr <= ad;
        bus.read <= 1'b1;
        @(posedge i_clock);
        bus.read <= 1'b0;
        @(negedge i_clock);
        dr = o_rdata;
    endtask

    task automatic cfg(input int g, input logic [31:0] c0, input logic [31:0] c1);
        wr(8'(32'h20 + 8 * g), c0);
        wr(8'(32'h24 + 8 * g), c1);
    endtask

    // Runs one measurement and checks phases and results against the model
    task automatic run_meas(input int g, input logic [15:0] need, input bit sy);
        logic [31:0] c0, c1;
        int p, dl, lim, cyc, rise, dcnt, ccnt, scnt, nch, ecnt;
        logic pc, ps, psc;
        c0 = regs[2 * g];
        c1 = regs[2 * g + 1];
        p = 2 * (int'(c0[31:16]) + 1);
        dl = int'(c1[23:16]) << c1[29:28];
        lim = (c1[15:0] < 2) ? 1 : int'(c1[15:0]);
        ecnt = (need < lim) ? need : lim;
        rise = -1;
        dcnt = 0;
        ccnt = 0;
        scnt = 0;
        nch = 0;
        pc = 0;
        ps = 0;
        psc = 0;
        @(posedge i_clock);
        acq_start <= 1'b1;
        pair_mode <= g ? TGAT_MODE_GROUP_B : TGAT_MODE_GROUP_A;
        need_r <= need;
        @(posedge i_clock);
        acq_start <= 1'b0;
        if (sy) begin
            repeat (30) begin
                @(negedge i_clock);
                `CHK(o_discharge, 1'b0);
            end
            @(posedge i_clock);
            sync_line <= 1'b0;
        end
        for (cyc = 0; cyc < 20000 && o_done !== 1'b1; cyc++) begin
            @(negedge i_clock);
            if (o_sample_clock === 1'b1 && psc === 1'b0) begin
                if (rise >= 0) `CHK(cyc - rise, p);
                rise = cyc;
            end
            psc = o_sample_clock;
            if (o_discharge === 1'b1) dcnt++;
            if (o_charge === 1'b1) ccnt++;
            else if (pc) begin
                `CHK(inr(ccnt, c0[15:8], p, c1[24] ? 3 : 0), 1'b1);
                nch++;
                ccnt = 0;
            end
            if (o_settle === 1'b1) scnt++;
            else if (ps) begin
                `CHK(inr(scnt, c0[7:0], p, 0), 1'b1);
                scnt = 0;
            end
            pc = (o_charge === 1'b1);
            ps = (o_settle === 1'b1);
        end
        if (o_done !== 1'b1) begin
            num_errors++;
            $display("Error at %0t: measurement never finished", $time);
            give_verdict();
        end
        `CHK(inr(dcnt, dl, p, 0), 1'b1);
        `CHK(o_count, 16'(ecnt));
        `CHK(o_max_reached, 1'(need > lim));
        `CHK(o_group_b, 1'(g));
        `CHK(nch, ecnt);
        `CHK(o_busy, 1'b1);
        @(negedge i_clock);
        `CHK(o_done, 1'b0);
        `CHK(o_busy, 1'b0);
        $display("Measurement group %0d need %0d finished", g, need);
    endtask

    // Main sequence
    initial begin
        bus = '0;
        acq_start = 1'b0;
        pair_mode = 3'h0;
        sync_line = 1'b1;
        need_r = 16'h0001;
        for (i = 0; i < 4; i++) regs[i] = TGAT_CFG_RESET;
        void'($urandom(26));
        repeat (16) @(posedge i_clock);
        i_reset <= 1'b0;
        for (i = 0; i < 5; i++) begin
            rd(8'(32'h20 + 4 * i), d);
            `CHK(d, 32'h0000_0000);
        end
        $display("Register reset test finished");
        for (i = 0; i < 6; i++) wr((i == 5) ? 8'h22 : 8'(32'h20 + 4 * i), $urandom);
        for (i = 0; i < 6; i++) begin
            a = (i == 5) ? 8'h22 : 8'(32'h20 + 4 * i);
            rd(a, d);
            `CHK(d, exp_rd(a));
        end
        $display("Register access test finished");
        for (s = 0; s < 4; s++) begin
            cfg(0, 32'h0001_0201, {2'b00, 2'(s), 4'h0, 8'h03, 16'h0040});
            run_meas(0, 16'($urandom_range(4, 1)), 1'b0);
        end
        cfg(1, 32'h0002_0102, 32'h0102_0003);
        run_meas(1, 16'h000A, 1'b0);
        cfg(1, 32'h0000_0101, 32'h1001_0000);
        run_meas(1, 16'h0005, 1'b0);
        for (m = 0; m < 8; m++) begin
            if (m != 1 && m != 2) begin
                @(posedge i_clock);
                acq_start <= 1'b1;
                pair_mode <= 3'(m);
                @(posedge i_clock);
                acq_start <= 1'b0;
                repeat (3) @(negedge i_clock);
                `CHK(o_busy, 1'b0);
            end
        end
        $display("Foreign mode test finished");
        cfg(0, 32'h0001_0202, 32'h0202_0008);
        run_meas(0, 16'h0003, 1'b1);
        give_verdict();
    end
endmodule

`default_nettype wire
